// >>> core/tbd_pkg.sv
// Package: register map, field layout, reset values and timing for the bias DAC sequencer
package tbd_pkg;
  // APB register byte offsets
  localparam logic [11:0] REG_ENABLE = 12'h000;
  localparam logic [11:0] REG_TURBO  = 12'h004;
  localparam logic [11:0] REG_DAC_A  = 12'h008;
  localparam logic [11:0] REG_DAC_B  = 12'h00C;
  localparam logic [11:0] REG_BOOST  = 12'h010;
  localparam logic [11:0] REG_TDLY   = 12'h014;
  localparam logic [11:0] REG_POWER  = 12'h018;
  localparam logic [11:0] REG_GLIDE  = 12'h01C;
  localparam logic [11:0] REG_STATUS = 12'h020;
  localparam logic [11:0] REG_LEVEL  = 12'h024;

  // Reset values
  localparam logic [3:0] BOOST_RST  = 4'hB;
  localparam logic [5:0] ENABLE_RST = 6'h00;
  localparam logic [7:0] TURBO_DELTA_RST = 8'h08;

  // Power state codes
  typedef enum logic [1:0] {
    PS_ACTIVE   = 2'b00,
    PS_STARTUP  = 2'b01,
    PS_LOWPOWER = 2'b10,
    PS_SHUTDOWN = 2'b11
  } tbd_pstate_t;

  // Per-output transition state
  typedef enum logic [1:0] {
    TR_IDLE  = 2'b00,
    TR_TURBO = 2'b01,
    TR_GLIDE = 2'b10
  } tbd_trans_t;

  // Timing
  localparam int MCLK_HZ      = 25000000;
  localparam int STARTUP_US   = 300;
  localparam int STARTUP_CYC  = 200;
  localparam int STEP_US_MIN  = 2;
  localparam int US_CYC       = MCLK_HZ / 1000000;
  localparam int SS_AVG_MHZ   = 2;
  localparam int SS_MIN_KHZ   = 800;
  localparam int SS_MAX_MHZ   = 4;
  // Half periods in mclk cycles: 4 MHz -> 3, 0.8 MHz -> 15, average near 2 MHz
  localparam int SS_HALF_MIN  = MCLK_HZ / (SS_MAX_MHZ * 2000000);
  localparam int SS_HALF_MAX  = MCLK_HZ / (SS_MIN_KHZ * 2000);
  localparam int SS_HALF_AVG  = MCLK_HZ / (SS_AVG_MHZ * 2000000);

  // Output drive bundle
  typedef struct packed {
    logic       enable;
    logic [7:0] level;
  } tbd_out_t;
endpackage

// >>> core/tbd_boost.sv
// Boost switching: hysteretic enable and spread-spectrum switching clock
module tbd_boost
  import tbd_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // Control
  input  wire logic run,
  input  wire logic ss_en,
  input  wire logic below_ref,
  // Switch drive
  output logic      sw_q
);
  logic       on_q;
  logic [4:0] cnt_q;
  logic [4:0] half_q;
  logic [7:0] lfsr_q;
  logic [4:0] half_d;
  wire  [4:0] span    = 5'(SS_HALF_MAX - SS_HALF_MIN + 1);
  wire  [4:0] rnd     = 5'(lfsr_q[4:0] % span);
  // Short draws on half the periods pull the mean rate up near 2 MHz
  wire  [4:0] rnd_sh  = {3'b000, lfsr_q[6:5]};
  wire  [4:0] pick    = lfsr_q[7] ? rnd : rnd_sh;

  assign half_d = ss_en ? 5'(SS_HALF_MIN) + pick : 5'(SS_HALF_AVG);

  always_ff @(posedge mclk) begin
    if (srst || !run) begin
      on_q   <= 1'b0;
      cnt_q  <= 5'h00;
      half_q <= 5'(SS_HALF_AVG);
      sw_q   <= 1'b0;
      lfsr_q <= 8'hA5;
    end else begin
      on_q <= below_ref;
      if (cnt_q + 5'h01 >= half_q) begin
        cnt_q  <= 5'h00;
        sw_q   <= on_q ? ~sw_q : 1'b0;
        lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        half_q <= half_d;
      end else begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  a_switch_stops: assert property (@(posedge mclk) disable iff (srst)
    (!run) |=> !sw_q)
    else $error("boost switches while not running");
  a_half_range: assert property (@(posedge mclk) disable iff (srst)
    (half_q >= 5'(SS_HALF_MIN)) && (half_q <= 5'(SS_HALF_MAX)))
    else $error("switching half period out of range");
endmodule

// >>> core/tbd_channel.sv
// One output channel: regular, turbo or glide transition toward the DAC code
module tbd_channel
  import tbd_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // Timebase
  input  wire logic       us_tick,
  // Settings
  input  wire logic       active,
  input  wire logic       en,
  input  wire logic       turbo_en,
  input  wire logic       glide_en,
  input  wire logic [7:0] code,
  input  wire logic       code_wr,
  input  wire logic [7:0] delta,
  input  wire logic [7:0] turbo_us,
  input  wire logic [4:0] glide_sel,
  // Drive
  output tbd_out_t        out_q,
  output logic            busy_q
);
  tbd_trans_t st_q;
  logic [7:0] cur_q;
  logic [7:0] tmr_q;
  wire        up       = code > cur_q;
  wire  [8:0] over     = {1'b0, code} + {1'b0, delta};
  wire  [7:0] turbo_hi = over[8] ? 8'hFF : over[7:0];
  wire  [7:0] turbo_lo = (code > delta) ? code - delta : 8'h00;
  // Step time 2..64 us, two microseconds per code
  wire  [7:0] step_us  = 8'(STEP_US_MIN) + {2'b00, glide_sel, 1'b0};
  wire        expired  = us_tick && (tmr_q == 8'h00);

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q   <= TR_IDLE;
      cur_q  <= 8'h00;
      tmr_q  <= 8'h00;
      out_q  <= '0;
      busy_q <= 1'b0;
    end else begin
      out_q.enable <= active && en;
      busy_q       <= st_q != TR_IDLE;
      if (us_tick && tmr_q != 8'h00)
        tmr_q <= tmr_q - 8'h01;
      case (st_q)
        TR_IDLE: begin
          if (code_wr && glide_en && code != cur_q) begin
            st_q  <= TR_GLIDE;
            tmr_q <= step_us - 8'h01;
          end else if (code_wr && turbo_en && code != cur_q) begin
            st_q      <= TR_TURBO;
            out_q.level <= up ? turbo_hi : turbo_lo;
            cur_q     <= code;
            tmr_q     <= turbo_us;
          end else if (code_wr) begin
            cur_q       <= code;
            out_q.level <= code;
          end
        end
        TR_TURBO: begin
          if (expired) begin
            st_q        <= TR_IDLE;
            out_q.level <= cur_q;
          end
        end
        TR_GLIDE: begin
          if (code_wr)
            tmr_q <= step_us - 8'h01;
          else if (expired) begin
            cur_q       <= up ? cur_q + 8'h01 : cur_q - 8'h01;
            out_q.level <= up ? cur_q + 8'h01 : cur_q - 8'h01;
            tmr_q       <= step_us - 8'h01;
            if (code == (up ? cur_q + 8'h01 : cur_q - 8'h01))
              st_q <= TR_IDLE;
          end else if (code == cur_q)
            st_q <= TR_IDLE;
        end
        default: st_q <= TR_IDLE;
      endcase
    end
  end

  a_glide_one_step: assert property (@(posedge mclk) disable iff (srst)
    (st_q == TR_GLIDE && $changed(cur_q)) |-> ((cur_q - $past(cur_q) == 8'h01) || ($past(cur_q) - cur_q == 8'h01)))
    else $error("glide moved by more than one code");
  a_disabled_hiz: assert property (@(posedge mclk) disable iff (srst)
    (!active) |=> !out_q.enable)
    else $error("output driven while inactive");
endmodule

// >>> core/tbd_top.sv
// Top: power sequencing, APB register file, boost and two output channels
//
// Local design decisions: the APB register port and the address map.
module tbd_top
  import tbd_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_US * US_CYC
)
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Supply monitors
  input  wire logic        io_supply,
  input  wire logic        below_ref,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Boost and outputs
  output logic             boost_sw,
  output logic      [3:0]  boost_level,
  output logic      [1:0]  out_en,
  output logic      [7:0]  out_a_level,
  output logic      [7:0]  out_b_level
);
  tbd_pstate_t ps_q;
  logic        io_prev_q;
  logic [13:0] su_cnt_q;
  logic [4:0]  us_cnt_q;
  logic        us_tick_q;
  logic        reg_rst;

  // Registers
  logic [5:0]  enable_q;
  logic        ss_en_q;
  logic [1:0]  turbo_q;
  logic [7:0]  code_q [2];
  logic [3:0]  boost_q;
  logic [7:0]  tdly_q;
  logic [7:0]  delta_q;
  logic [1:0]  glide_q;
  logic [4:0]  gsel_q;
  logic [1:0]  wr_code_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  tbd_out_t    ch_out [2];
  logic [1:0]  ch_busy;

  wire io_rise   = io_supply && !io_prev_q;
  wire active    = ps_q == PS_ACTIVE;
  wire setup_ph  = psel && !penable;
  wire acc       = psel && penable && pready_q;
  wire wr        = acc && pwrite;
  wire power_cmd = wr && paddr == REG_POWER;
  wire to_start  = power_cmd && pwdata[1:0] == PS_STARTUP;

  // Register reset on supply loss, supply rise, or a startup command
  assign reg_rst = srst || !io_supply || io_rise || to_start;

  wire mapped = paddr == REG_ENABLE || paddr == REG_TURBO || paddr == REG_DAC_A ||
                paddr == REG_DAC_B || paddr == REG_BOOST || paddr == REG_TDLY ||
                paddr == REG_POWER || paddr == REG_GLIDE || paddr == REG_STATUS ||
                paddr == REG_LEVEL;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      REG_ENABLE: rd_mux = {25'h0, ss_en_q, enable_q};
      REG_TURBO:  rd_mux = {22'h0, turbo_q, delta_q};
      REG_DAC_A:  rd_mux = {24'h0, code_q[0]};
      REG_DAC_B:  rd_mux = {24'h0, code_q[1]};
      REG_BOOST:  rd_mux = {28'h0, boost_q};
      REG_TDLY:   rd_mux = {24'h0, tdly_q};
      REG_POWER:  rd_mux = {30'h0, ps_q};
      REG_GLIDE:  rd_mux = {25'h0, glide_q, gsel_q};
      REG_STATUS: rd_mux = {28'h0, ch_busy, ps_q};
      REG_LEVEL:  rd_mux = {16'h0, ch_out[1].level, ch_out[0].level};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // Power sequencing
  always_ff @(posedge mclk) begin
    if (srst) begin
      ps_q      <= PS_SHUTDOWN;
      io_prev_q <= 1'b0;
      su_cnt_q  <= 14'h0000;
    end else begin
      io_prev_q <= io_supply;
      if (!io_supply) begin
        ps_q <= PS_SHUTDOWN;
      end else if (io_rise || to_start) begin
        ps_q     <= PS_STARTUP;
        su_cnt_q <= 14'h0000;
      end else if (ps_q == PS_STARTUP) begin
        su_cnt_q <= su_cnt_q + 14'h0001;
        if (su_cnt_q >= 14'(STARTUP_CYC - 1))
          ps_q <= PS_ACTIVE;
      end else if (power_cmd && pwdata[1:0] == PS_LOWPOWER && active) begin
        ps_q <= PS_LOWPOWER;
      end else if (power_cmd && pwdata[1:0] == PS_ACTIVE && ps_q == PS_LOWPOWER) begin
        ps_q <= PS_ACTIVE;
      end
    end
  end

  // Free-running microsecond timebase
  always_ff @(posedge mclk) begin
    if (srst) begin
      us_cnt_q  <= 5'h00;
      us_tick_q <= 1'b0;
    end else begin
      us_tick_q <= us_cnt_q == 5'(US_CYC - 1);
      us_cnt_q  <= (us_cnt_q == 5'(US_CYC - 1)) ? 5'h00 : us_cnt_q + 5'h01;
    end
  end

  // Startup age, counted here because the bound is too long for a delay range
  logic [12:0] su_age_q;
  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      su_age_q <= '0;
    end else if (ps_q == PS_STARTUP && su_age_q != '1) begin
      su_age_q <= su_age_q + 13'h0001;
    end
  end

  // Register file; writes only land when the interface is up
  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      enable_q  <= ENABLE_RST;
      ss_en_q   <= 1'b1;
      turbo_q   <= 2'b00;
      code_q[0] <= 8'h00;
      code_q[1] <= 8'h00;
      boost_q   <= BOOST_RST;
      tdly_q    <= 8'h0A;
      delta_q   <= TURBO_DELTA_RST;
      glide_q   <= 2'b00;
      gsel_q    <= 5'h00;
      wr_code_q <= 2'b00;
    end else begin
      wr_code_q <= 2'b00;
      if (wr && ps_q != PS_SHUTDOWN) begin
        case (paddr)
          REG_ENABLE: begin
            enable_q <= pwdata[5:0];
            ss_en_q  <= pwdata[6];
          end
          REG_TURBO: begin
            delta_q <= pwdata[7:0];
            turbo_q <= pwdata[9:8];
          end
          REG_DAC_A: begin
            code_q[0]    <= pwdata[7:0];
            wr_code_q[0] <= 1'b1;
          end
          REG_DAC_B: begin
            code_q[1]    <= pwdata[7:0];
            wr_code_q[1] <= 1'b1;
          end
          REG_BOOST: boost_q <= pwdata[3:0];
          REG_TDLY:  tdly_q  <= pwdata[7:0];
          REG_GLIDE: begin
            gsel_q  <= pwdata[4:0];
            glide_q <= pwdata[6:5];
          end
          default: ;
        endcase
      end
    end
  end

  // APB answer: one wait state, ready on the second access cycle
  // Interface logic starts over with every register reset
  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped;
      prdata_q  <= (psel && penable && !pready_q && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      tbd_channel u_ch (
        .mclk      (mclk),
        .srst      (reg_rst),
        .us_tick   (us_tick_q),
        .active    (active),
        .en        (enable_q[3 - g]),
        .turbo_en  (turbo_q[g] && !glide_q[g]),
        .glide_en  (glide_q[g]),
        .code      (code_q[g]),
        .code_wr   (wr_code_q[g]),
        .delta     (delta_q),
        .turbo_us  (tdly_q),
        .glide_sel (gsel_q),
        .out_q     (ch_out[g]),
        .busy_q    (ch_busy[g])
      );
    end
  endgenerate

  tbd_boost u_boost (
    .mclk      (mclk),
    .srst      (srst),
    .run       (ps_q == PS_ACTIVE || ps_q == PS_STARTUP),
    .ss_en     (ss_en_q),
    .below_ref (below_ref),
    .sw_q      (boost_sw)
  );

  // Output flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      boost_level <= BOOST_RST;
      out_en      <= 2'b00;
      out_a_level <= 8'h00;
      out_b_level <= 8'h00;
    end else begin
      boost_level <= boost_q;
      out_en      <= {ch_out[1].enable, ch_out[0].enable} & {2{active}};
      out_a_level <= ch_out[0].level;
      out_b_level <= ch_out[1].level;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // Checks on sequencing and on the bus answer
  a_shutdown_hiz: assert property (@(posedge mclk) disable iff (srst)
    (!io_supply) |=> ##1 (out_en == 2'b00))
    else $error("outputs driven in shutdown");
  a_reset_boost: assert property (@(posedge mclk) disable iff (srst)
    (io_rise) |=> (boost_q == BOOST_RST && enable_q == ENABLE_RST))
    else $error("bad defaults");
  a_level_default: assert property (@(posedge mclk) disable iff (srst)
    (io_rise) |=> ##1 (boost_level == BOOST_RST && out_en == 2'b00))
    else $error("bad default outputs");
  a_startup_time: assert property (@(posedge mclk) disable iff (srst)
    su_age_q <= 13'(STARTUP_CYCLES))
    else $error("startup too slow");
  a_shutdown_state: assert property (@(posedge mclk) disable iff (srst)
    (!io_supply) |=> ps_q == PS_SHUTDOWN)
    else $error("no shutdown on low supply");
  a_no_rearm: assert property (@(posedge mclk) disable iff (srst)
    (active && io_supply && $past(io_supply) && !to_start) |=> ps_q != PS_STARTUP)
    else $error("spurious reset");
  a_cmd_reset: assert property (@(posedge mclk) disable iff (srst)
    (to_start && io_supply) |=> (ps_q == PS_STARTUP && boost_q == BOOST_RST && enable_q == ENABLE_RST))
    else $error("startup command did not reset");
  a_lowpower_quiet: assert property (@(posedge mclk) disable iff (srst)
    (ps_q == PS_LOWPOWER) |=> (!boost_sw && out_en == 2'b00))
    else $error("boost or outputs running in low power");
  a_wake_active: assert property (@(posedge mclk) disable iff (srst)
    (ps_q == PS_LOWPOWER && io_supply && power_cmd && pwdata[1:0] == PS_ACTIVE) |=> active)
    else $error("no wake from low power");
  a_ready_waits: assert property (@(posedge mclk) disable iff (srst || !io_supply)
    (psel && penable && !pready_q && !reg_rst) |=> pready_q)
    else $error("bus answer missing after one wait state");
  a_ready_not_setup: assert property (@(posedge mclk) disable iff (srst)
    (setup_ph) |-> !pready_q)
    else $error("ready raised in setup cycle");
endmodule

// >>> verif/tbd_apb_master.sv
// APB master model standing in for the controlling party
module tbd_apb_master (
  // Clock
  input  wire logic        mclk,
  // Request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  // Answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'hFFF;
    pwdata  = 32'hFFFFFFFF;
  end

  // Holds the request until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // No limit here; the bench watchdog ends a hung wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines do not keep the last value
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

// >>> verif/tbd_top_tb_top.sv
// Testbench for the bias DAC sequencer top
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin errors++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, ex, gt); end end
module tbd_top_tb_top
  import tbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk, srst, io_supply, below_ref;
  logic        psel, penable, pwrite, pready, pslverr, boost_sw;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  boost_level;
  logic [1:0]  out_en;
  logic [7:0]  out_a_level, out_b_level;
  logic        e;
  int          errors, n_tests, cyc, t0, c;

  tbd_top #(.STARTUP_CYCLES(STARTUP_CYC)) uut (
    .mclk(mclk), .srst(srst), .io_supply(io_supply), .below_ref(below_ref),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .boost_sw(boost_sw),
    .boost_level(boost_level), .out_en(out_en), .out_a_level(out_a_level),
    .out_b_level(out_b_level)
  );

  tbd_apb_master m (
    .mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  always #20 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rr;
    logic        ee;
    m.xfer(1'b1, a, d, rr, ee);
  endtask

  task automatic rd(input logic [11:0] a);
    m.xfer(1'b0, a, 32'h0, r, e);
  endtask

  // Polls status until the masked bits match, bounded
  task automatic wait_status(input logic [31:0] mask, input logic [31:0] val);
    int n;
    n = 0;
    do begin
      rd(REG_STATUS);
      n++;
    end while ((r & mask) !== val && n < 2500);
    `CHK("status_wait", val, r & mask)
  endtask

  task automatic power_up;
    io_supply <= 1'b1;
    t0 = cyc;
    repeat (3) @(posedge mclk);
    rd(REG_STATUS);
    `CHK("state_startup", PS_STARTUP, r[1:0])
    wait_status(32'h3, 32'h0);
    `CHK("startup_time", 1'b1, (cyc - t0) <= STARTUP_US * US_CYC)
  endtask

  // Rising edges of the switch drive over n cycles
  task automatic cnt(input int n, output int k);
    logic p;
    k = 0;
    p = boost_sw;
    repeat (n) begin
      @(posedge mclk);
      if (boost_sw === 1'b1 && p !== 1'b1) k++;
      p = boost_sw;
    end
  endtask

  task give_verdict;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    give_verdict();
  end

  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    io_supply = 1'b0;
    below_ref = 1'b0;
    cyc = 0;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    power_up();
    `CHK("boost_def", BOOST_RST, boost_level)
    `CHK("out_en_def", 2'b00, out_en)
    rd(REG_ENABLE);
    `CHK("en_def", 2'b00, r[3:2])
    rd(12'h030);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_data", 32'h0, r)
    wr(REG_ENABLE, 32'h48);
    wr(REG_DAC_A, 32'h10);
    repeat (4) @(posedge mclk);
    `CHK("a_enable", 2'b01, out_en)
    `CHK("a_regular", 8'h10, out_a_level)
    // Glide on A with its turbo bit also set, turbo on B
    wr(REG_BOOST, 32'hB);
    wr(REG_TURBO, 32'h308);
    wr(REG_GLIDE, 32'h20);
    wr(REG_ENABLE, 32'h4C);
    wr(REG_DAC_A, 32'h18);
    repeat (4) @(posedge mclk);
    `CHK("glide_mid", 1'b1, out_a_level < 8'h18)
    wr(REG_DAC_B, 32'h40);
    repeat (4) @(posedge mclk);
    `CHK("turbo_over", 8'h48, out_b_level)
    repeat (150) @(posedge mclk);
    `CHK("glide_no_turbo", 1'b1, out_a_level < 8'h18)
    wr(REG_DAC_A, 32'h11);
    `CHK("glide_restart", 1'b1, out_a_level > 8'h11)
    repeat (150) @(posedge mclk);
    `CHK("turbo_end", 8'h40, out_b_level)
    wait_status(32'hC, 32'h0);
    `CHK("glide_end", 8'h11, out_a_level)
    rd(REG_LEVEL);
    `CHK("levels", 16'h4011, r[15:0])
    // Hysteretic switching and its spread clock
    below_ref <= 1'b1;
    cnt(1000, c);
    `CHK("sw_rate", 1'b1, c >= 60 && c <= 100)
    wr(REG_ENABLE, 32'h0C);
    cnt(1000, c);
    `CHK("sw_fixed", 1'b1, c >= 80 && c <= 84)
    below_ref <= 1'b0;
    repeat (40) @(posedge mclk);
    cnt(100, c);
    `CHK("sw_stop", 0, c)
    // Low power keeps registers, stops outputs and boost
    wr(REG_BOOST, 32'h7);
    below_ref <= 1'b1;
    wr(REG_POWER, 32'h2);
    repeat (20) @(posedge mclk);
    cnt(100, c);
    `CHK("lp_boost_off", 0, c)
    `CHK("lp_out_off", 2'b00, out_en)
    `CHK("lp_keep", 4'h7, boost_level)
    rd(REG_STATUS);
    `CHK("lp_state", PS_LOWPOWER, r[1:0])
    wr(REG_POWER, 32'h0);
    rd(REG_STATUS);
    `CHK("lp_wake", PS_ACTIVE, r[1:0])
    wr(REG_POWER, 32'h1);
    wait_status(32'h3, 32'h0);
    `CHK("cmd_reset", BOOST_RST, boost_level)
    // Supply loss drops everything
    wr(REG_BOOST, 32'h3);
    wr(REG_ENABLE, 32'h4C);
    io_supply <= 1'b0;
    repeat (5) @(posedge mclk);
    `CHK("sd_hiz", 2'b00, out_en)
    `CHK("sd_lost", BOOST_RST, boost_level)
    cnt(100, c);
    `CHK("sd_boost_off", 0, c)
    power_up();
    give_verdict();
  end
endmodule
